/* File: core/autobaud_pkg.sv */
package autobaud_pkg;
  localparam int unsigned PARAM_W = 16;
  localparam int unsigned CLK_MHZ = 100;
  // one machine cycle is two clock cycles
  localparam int unsigned CLK_PER_MCYC = 2;
  localparam int unsigned BIT_BASE_MCYC = 83;
  localparam int unsigned BIT_STEP_MCYC = 14;
  localparam int unsigned ID_STEP_MCYC = 84;
  localparam logic [PARAM_W-1:0] ID_PRESET = 16'hFFFA;
  localparam logic [3:0] TX_BITS_TWO_STOP = 4'hB;
  localparam logic [3:0] TX_BITS_ONE_STOP = 4'hA;
  localparam logic [3:0] RX_SAMPLES = 4'h9;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [PARAM_W-1:0] RESET_FULL_BIT = 16'h0157;
  localparam logic [PARAM_W-1:0] RESET_HALF_BIT = 16'h012C;
  localparam logic [23:0] BASE_CLKS = 24'(BIT_BASE_MCYC * CLK_PER_MCYC);
  localparam logic [23:0] STEP_CLKS = 24'(BIT_STEP_MCYC * CLK_PER_MCYC);
  localparam logic [23:0] ID_STEP_CLKS = 24'(ID_STEP_MCYC * CLK_PER_MCYC);
endpackage : autobaud_pkg

/* File: core/autobaud_serial_port.sv */
`timescale 1ns/1ps
`default_nettype none
module autobaud_serial_port
  import autobaud_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic serial_in_pin_in,
  output logic serial_out_pin_out,
  input wire logic rate_identify_in,
  output logic identify_busy_out,
  input wire logic one_stop_in,
  input wire logic char_transmit_in,
  input wire logic [7:0] tx_char_in,
  output logic tx_busy_out,
  output logic tx_done_out,
  input wire logic char_receive_in,
  output logic rx_busy_out,
  output logic rx_done_out,
  output logic [7:0] rx_char_out,
  output logic [PARAM_W-1:0] full_bit_param_out,
  output logic [PARAM_W-1:0] half_bit_param_out
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser: three stages, edge only when stages two and three agree
  // the filter flop follows only once two stages agree, so a one-cycle glitch is dropped
  logic [2:0] sync;
  logic rx_line;
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync <= 3'h7;
      rx_line <= 1'b1;
    end else begin
      sync <= {sync[1:0], serial_in_pin_in};
      if (sync[1] == sync[2]) begin
        rx_line <= sync[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit period from a byte-coded parameter: reduce each byte then scale
  function automatic logic [23:0] period_clks(input logic [PARAM_W-1:0] p);
    logic [15:0] reduced;
    reduced = {p[15:8] - BYTE_ONE, p[7:0] - BYTE_ONE};
    return BASE_CLKS + 24'(reduced) * STEP_CLKS;
  endfunction : period_clks

  // half wait counts only half the fixed overhead, so half plus full sits 1.5 bits out
  function automatic logic [23:0] half_clks(input logic [PARAM_W-1:0] p);
    logic [15:0] reduced;
    reduced = {p[15:8] - BYTE_ONE, p[7:0] - BYTE_ONE};
    return (BASE_CLKS >> 1) + 24'(reduced) * STEP_CLKS;
  endfunction : half_clks

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_ID_HIGH = 3'h1,
    S_ID_FALL = 3'h2,
    S_ID_LOW = 3'h3,
    S_TX = 3'h4,
    S_RX_START = 3'h5,
    S_RX_BITS = 3'h6
  } state_t;

  state_t state, next_state;
  logic [23:0] timer, next_timer;
  logic [3:0] bits, next_bits;
  logic [8:0] shifter, next_shifter;
  logic [PARAM_W-1:0] meas, next_meas;
  logic [PARAM_W-1:0] full_bit, next_full_bit, half_bit, next_half_bit;
  logic line_out, next_line_out, tx_done, next_tx_done, rx_done, next_rx_done;
  logic [7:0] rx_char, next_rx_char;
  logic [PARAM_W-1:0] halved;

  always_comb begin
    next_state = state;
    next_timer = timer;
    next_bits = bits;
    next_shifter = shifter;
    next_meas = meas;
    next_full_bit = full_bit;
    next_half_bit = half_bit;
    next_line_out = line_out;
    next_tx_done = 1'b0;
    next_rx_done = 1'b0;
    next_rx_char = rx_char;
    halved = meas >> 1;
    unique case (state)
      S_IDLE: begin
        next_line_out = 1'b1;
        if (rate_identify_in) begin
          next_state = S_ID_HIGH;
        end else if (char_transmit_in) begin
          // byte sits above the carry so each rotate brings the next data bit to bit zero
          next_shifter = {tx_char_in, 1'b0}; // carry starts at zero
          next_line_out = 1'b0;
          next_bits = one_stop_in ? TX_BITS_ONE_STOP : TX_BITS_TWO_STOP;
          next_timer = period_clks(full_bit);
          next_state = S_TX;
        end else if (char_receive_in) begin
          next_state = S_RX_START;
        end
      end
      S_ID_HIGH: begin
        if (rx_line) begin
          next_state = S_ID_FALL;
        end
      end
      S_ID_FALL: begin
        if (!rx_line) begin
          next_meas = ID_PRESET;
          next_timer = ID_STEP_CLKS;
          next_state = S_ID_LOW;
        end
      end
      S_ID_LOW: begin
        if (rx_line) begin
          // steps round down, so a low just short of a step reads one rate faster
          // measured low spans six bits of the space character
          next_full_bit = {meas[15:8] + BYTE_ONE, meas[7:0] + BYTE_ONE};
          next_half_bit = {halved[15:8] + BYTE_ONE, halved[7:0] + BYTE_ONE};
          next_state = S_IDLE;
        end else if (timer == 24'h000001) begin
          next_meas = meas + 16'h0001;
          next_timer = ID_STEP_CLKS;
        end else begin
          next_timer = timer - 24'h000001;
        end
      end
      S_TX: begin
        if (timer == 24'h000001) begin
          // carry set to one then the nine bits rotate right
          next_shifter = {1'b1, shifter[8:1]};
          next_bits = bits - 4'h1;
          if (bits == 4'h1) begin
            next_line_out = 1'b1;
            next_tx_done = 1'b1;
            next_state = S_IDLE;
          end else begin
            next_line_out = shifter[1];
            next_timer = period_clks(full_bit);
          end
        end else begin
          next_timer = timer - 24'h000001;
        end
      end
      S_RX_START: begin
        if (!rx_line) begin
          // half bit plus a full bit, both loaded here, puts the first sample at 1.5 bits
          next_timer = half_clks(half_bit) + period_clks(full_bit);
          next_bits = RX_SAMPLES;
          next_state = S_RX_BITS;
        end
      end
      S_RX_BITS: begin
        if (timer == 24'h000001) begin
          next_bits = bits - 4'h1;
          next_timer = period_clks(full_bit);
          if (bits == 4'h1) begin
            next_rx_done = 1'b1; // ninth sample is the stop bit, not kept
            next_state = S_IDLE;
          end else begin
            // the line arrives a few cycles late through the filter, still far inside the bit
            next_rx_char = {rx_line, rx_char[7:1]};
          end
        end else begin
          next_timer = timer - 24'h000001;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // parameters only change on the identify path
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= S_IDLE;
      timer <= 24'h000000;
      bits <= 4'h0;
      shifter <= 9'h1FF;
      meas <= 16'h0000;
      full_bit <= RESET_FULL_BIT;
      half_bit <= RESET_HALF_BIT;
      line_out <= 1'b1;
      tx_done <= 1'b0;
      rx_done <= 1'b0;
      rx_char <= 8'h00;
      identify_busy_out <= 1'b0;
      tx_busy_out <= 1'b0;
      rx_busy_out <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      bits <= next_bits;
      shifter <= next_shifter;
      meas <= next_meas;
      full_bit <= next_full_bit;
      half_bit <= next_half_bit;
      line_out <= next_line_out;
      tx_done <= next_tx_done;
      rx_done <= next_rx_done;
      rx_char <= next_rx_char;
      // busy follows the next state so it rises with the first cycle of the work
      identify_busy_out <= next_state inside {S_ID_HIGH, S_ID_FALL, S_ID_LOW};
      tx_busy_out <= next_state == S_TX;
      rx_busy_out <= next_state inside {S_RX_START, S_RX_BITS};
    end
  end

  assign serial_out_pin_out = line_out;
  assign tx_done_out = tx_done;
  assign rx_done_out = rx_done;
  assign rx_char_out = rx_char;
  assign full_bit_param_out = full_bit;
  assign half_bit_param_out = half_bit;

  ////////////////////////////////////////////////////////////////////////////
  // internal state is watched where no port shows the step being checked
  chk_tx_start_low: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (state == S_IDLE && !rate_identify_in && char_transmit_in) |=> !serial_out_pin_out)
    else $error("start bit not low");
  chk_tx_end_high: assert property (@(posedge core_clk_in) disable iff (rst_in)
    tx_done_out |-> serial_out_pin_out)
    else $error("line not high after frame");
  chk_tx_bit_count: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (state == S_IDLE && !rate_identify_in && char_transmit_in) |=>
    (bits == ($past(one_stop_in) ? TX_BITS_ONE_STOP : TX_BITS_TWO_STOP)))
    else $error("wrong bit count");
  chk_carry_set: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (state == S_TX && timer == 24'h000001) |=> shifter[8])
    else $error("carry not set to one");
  chk_rx_lsb_first: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (state == S_RX_BITS && timer == 24'h000001 && bits != 4'h1) |=> rx_char[7] == $past(rx_line))
    else $error("sample not shifted in");
  chk_rx_keeps_stop: assert property (@(posedge core_clk_in) disable iff (rst_in)
    rx_done_out |-> $stable(rx_char_out))
    else $error("stop bit stored");
  chk_id_preset: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (state == S_ID_FALL && !rx_line) |=> meas == ID_PRESET)
    else $error("preset wrong");
  chk_param_hold: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (state != S_ID_LOW) |=> $stable(full_bit) && $stable(half_bit))
    else $error("parameter changed");
  chk_done_pulse: assert property (@(posedge core_clk_in) disable iff (rst_in)
    tx_done_out |=> !tx_done_out)
    else $error("done too long");
  chk_rx_done_pulse: assert property (@(posedge core_clk_in) disable iff (rst_in)
    rx_done_out |=> !rx_done_out)
    else $error("receive done too long");
  chk_tx_line_shift: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (state == S_TX && timer == 24'h000001 && bits != 4'h1) |=> serial_out_pin_out == $past(shifter[1]))
    else $error("line not fed from rotator");
  chk_tx_holds_frame: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (state == S_TX && timer != 24'h000001) |=> state == S_TX)
    else $error("frame cut short");
  chk_idle_line_high: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (state == S_IDLE) |-> serial_out_pin_out)
    else $error("line low while idle");
  chk_rx_sample_count: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (state == S_RX_START && !rx_line) |=> bits == RX_SAMPLES)
    else $error("wrong sample count");
  chk_id_step: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (state == S_ID_LOW && !rx_line && timer == 24'h000001) |=> meas == $past(meas) + 16'h0001)
    else $error("measure not stepped");
  chk_id_wait_high: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (state == S_ID_HIGH && !rx_line) |=> state == S_ID_HIGH)
    else $error("measure began without idle line");
  chk_id_priority: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (state == S_IDLE && rate_identify_in) |=> state == S_ID_HIGH)
    else $error("identify request not taken");
  // covers: a one-stop frame request, a refused request, each kind of completion
  cov_tx: cover property (@(posedge core_clk_in) tx_done_out);
  cov_rx: cover property (@(posedge core_clk_in) rx_done_out);
  cov_id: cover property (@(posedge core_clk_in) state == S_ID_LOW && rx_line);
  cov_tx_one_stop: cover property (@(posedge core_clk_in) state == S_IDLE && char_transmit_in && one_stop_in);
  cov_tx_refused: cover property (@(posedge core_clk_in) state == S_TX && char_transmit_in);

endmodule : autobaud_serial_port
`default_nettype wire

/* File: verif/serial_terminal.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module serial_terminal (
  input wire logic clk_in,
  input wire logic line_in,
  output logic line_out
);
  // set by the bench before each send and receive test; the identify character goes at the initial 350
  int bit_clks = 350;

  initial line_out = 1'b1;

  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= f[i];
      repeat (bit_clks) @(posedge clk_in);
    end
    line_out <= 1'b1;
  endtask : send

  // samples at bit centres; ok means low start and high first stop
  task automatic recv(output logic [7:0] b, output logic ok);
    int n;
    b = 8'h00;
    n = 0;
    while (line_in !== 1'b0 && n < 50000) begin
      @(posedge clk_in);
      n++;
    end
    repeat (bit_clks / 2) @(posedge clk_in);
    ok = (n < 50000) && (line_in === 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_clks) @(posedge clk_in);
      b[i] = line_in;
    end
    repeat (bit_clks) @(posedge clk_in);
    ok = ok && (line_in === 1'b1);
  endtask : recv
endmodule : serial_terminal
`default_nettype wire

/* File: verif/autobaud_serial_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module autobaud_serial_port_tb;
  import autobaud_pkg::*;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic rate_identify_in = 1'b0;
  logic one_stop_in = 1'b0;
  logic char_transmit_in = 1'b0;
  logic [7:0] tx_char_in = 8'h00;
  logic char_receive_in = 1'b0;
  logic sin, sout, id_busy, tx_busy, tx_done, rx_busy, rx_done;
  logic [7:0] rx_char;
  logic [PARAM_W-1:0] full, half;
  int fails = 0;
  int n_checks = 0;

  always #5 core_clk_in = ~core_clk_in;

  autobaud_serial_port i_autobaud_serial_port (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .serial_in_pin_in(sin), .serial_out_pin_out(sout), .rate_identify_in(rate_identify_in),
    .identify_busy_out(id_busy), .one_stop_in(one_stop_in), .char_transmit_in(char_transmit_in),
    .tx_char_in(tx_char_in), .tx_busy_out(tx_busy), .tx_done_out(tx_done),
    .char_receive_in(char_receive_in), .rx_busy_out(rx_busy), .rx_done_out(rx_done),
    .rx_char_out(rx_char), .full_bit_param_out(full), .half_bit_param_out(half));
  serial_terminal i_serial_terminal (.clk_in(core_clk_in), .line_in(sout), .line_out(sin));

////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  task automatic chk(input bit c, input string m);
    n_checks++;
    if (!c) begin
      fails++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk

  // clocks per bit, two clocks per machine cycle
  function automatic int per(input logic [15:0] p);
    return 2 * (83 + 14 * (256 * (int'(p[15:8]) - 1) + int'(p[7:0]) - 1));
  endfunction : per

  function automatic logic pick(input int s);
    case (s)
      0: return tx_done;
      1: return rx_done;
      default: return id_busy;
    endcase
  endfunction : pick

  task automatic wait_for(input int s, input logic v, output int n);
    n = 0;
    while (pick(s) !== v) begin
      @(posedge core_clk_in);
      #1;
      n++;
      if (n > 60000) begin
        chk(1'b0, "wait timed out");
        conclude();
      end
    end
  endtask : wait_for

////////////////////////////////////////////////////////////////////////////////
  task automatic t_ident();
    int n;
    @(posedge core_clk_in);
    rate_identify_in <= 1'b1;
    @(posedge core_clk_in);
    rate_identify_in <= 1'b0;
    repeat (20) @(posedge core_clk_in);
    #1;
    chk(id_busy === 1'b1, "identify not busy");
    i_serial_terminal.send(8'h20);
    wait_for(2, 1'b0, n);
    chk(full === 16'h0107 || full === 16'h0108, "full param");
    chk(half === ((full - 16'h0101) >> 1) + 16'h0101, "half param");
  endtask : t_ident

  // a second request mid-frame must be ignored
  task automatic t_send(input logic [7:0] b, input logic os);
    logic [7:0] got;
    logic ok;
    int n, p;
    p = per(full) * (os ? 10 : 11);
    i_serial_terminal.bit_clks = per(full);
    @(posedge core_clk_in);
    char_transmit_in <= 1'b1;
    tx_char_in <= b;
    one_stop_in <= os;
    @(posedge core_clk_in);
    char_transmit_in <= 1'b0;
    fork
      i_serial_terminal.recv(got, ok);
      begin
        repeat (50) @(posedge core_clk_in);
        char_transmit_in <= 1'b1;
        tx_char_in <= ~b;
        @(posedge core_clk_in);
        char_transmit_in <= 1'b0;
        wait_for(0, 1'b1, n);
      end
    join
    chk(got === b && ok === 1'b1, "tx frame");
    chk(n + 52 >= p - 3 && n + 52 <= p + 3, "tx length");
    @(posedge core_clk_in);
    #1;
    chk(tx_done === 1'b0 && tx_busy === 1'b0 && sout === 1'b1, "tx end");
  endtask : t_send

  // ninth sample 9.5 bits after the synced edge; an odd parameter rounds the half down by half a step
  task automatic t_recv(input logic [7:0] b);
    int n, e;
    logic [PARAM_W-1:0] f0;
    f0 = full;
    e = (19 * per(full)) / 2;
    i_serial_terminal.bit_clks = per(full);
    @(posedge core_clk_in);
    char_receive_in <= 1'b1;
    @(posedge core_clk_in);
    char_receive_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    chk(rx_busy === 1'b1, "rx not busy");
    fork
      i_serial_terminal.send(b);
      begin
        wait_for(1, 1'b1, n);
        chk(rx_busy === 1'b0, "rx busy after done");
        @(posedge core_clk_in);
        #1;
        chk(rx_done === 1'b0, "rx done too long");
      end
    join
    chk(rx_char === b, "rx char");
    chk(n >= e - 14 && n <= e + 8, "rx timing");
    chk(full === f0, "param changed");
  endtask : t_recv

////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge core_clk_in);
    rst_in <= 1'b0;
    #1;
    chk(full === 16'h0157 && half === 16'h012C && sout === 1'b1, "reset state");
    t_ident();
    t_send(8'hA5, 1'b0);
    t_send(8'h3C, 1'b1);
    t_recv(8'h81);
    t_recv(8'h5A);
    @(posedge core_clk_in);
    rst_in <= 1'b1;
    #1;
    chk(full === 16'h0157 && half === 16'h012C, "mid-run reset");
    conclude();
  end
endmodule : autobaud_serial_port_tb
`default_nettype wire
